// >>> design/cspip_defs.vh
/*
 * constants for the cpu stack and indirect pointer block.
 * assumes inclusion by bare name from the design and monitor files.
 */
`ifndef CSPIP_DEFS_VH
`define CSPIP_DEFS_VH

// ****************************************
// stack geometry
// ****************************************
`define CSPIP_PC_W 15
`define CSPIP_STK_DEPTH 16
`define CSPIP_STK_PTR_W 4

// ****************************************
// vectors and memory sizes
// ****************************************
`define CSPIP_RESET_VEC 15'h0000
`define CSPIP_INT_VEC 15'h0004
`define CSPIP_PROG_WORDS 8192
`define CSPIP_PROG_ADDR_W 13
`define CSPIP_LAST_PROG_ADDR 15'h7fff

// ****************************************
// pointers and data memory
// ****************************************
`define CSPIP_PTR_W 16
`define CSPIP_PTR_PROG_BIT 15
`define CSPIP_DATA_ADDR_W 12
`define CSPIP_GPR_BANK_BYTES 80
`define CSPIP_LIN_BASE 16'h2000
`define CSPIP_LIN_TOP 16'h29af
`define CSPIP_GPR_OFS 7'h20
`define CSPIP_BANK_SIZE 8'h80

// ****************************************
// instruction set and opcodes handled here
// ****************************************
`define CSPIP_NUM_INSTR 49
`define CSPIP_OP_W 3
`define CSPIP_OP_NONE 3'h0
`define CSPIP_OP_CALL 3'h1
`define CSPIP_OP_RET 3'h2
`define CSPIP_OP_RETFIE 3'h3
`define CSPIP_OP_PTR_ADD 3'h4
`define CSPIP_OP_PTR_LOAD 3'h5
`define CSPIP_OP_IND_RD 3'h6
`define CSPIP_OP_IND_WR 3'h7

// ****************************************
// shadow context width: w, status, bsr, pclath, two pointers
// ****************************************
`define CSPIP_CTX_W 62

`endif

// >>> design/cspip_core.v
/*
 * stack, context shadowing and the two indirect pointers of the cpu core.
 * assumes the sequencer presents one op per instruction cycle (op_valid_in),
 * holds it while busy_out is high and returns read data on the memory ports.
 */
`timescale 1ns/1ps
`include "cspip_defs.vh"

// Operation
// - return stack holds sixteen fifteen-bit program counter entries.
// - push past full sets overflow flag, pop when empty sets underflow flag.
// - with stack reset option on, a stack error also requests software reset.
// - interrupt entry saves context to shadows; return from interrupt restores it.
// - two sixteen-bit pointers address every file register and program memory.
// - indirect access to program memory takes one extra instruction cycle.
// - linear window maps contiguous addresses onto the 80-byte gpr banks.
// - program memory is 8192 words, addresses to 7fffh wrap into it.
// - core supports 49 instructions, pointer ones handled in this block.
// - pointer bit 15 selects program memory; low byte read, writes ignored.
// - reset starts at 0000h, interrupts vector to 0004h.
module cspip_core (
    input wire clk_in,
    input wire sys_rst_in,
    input wire stack_reset_en_in,
    input wire op_valid_in,
    input wire [`CSPIP_OP_W-1:0] op_in,
    input wire ptr_sel_in,
    input wire [`CSPIP_PTR_W-1:0] ptr_value_in,
    input wire [`CSPIP_PC_W-1:0] pc_in,
    input wire [`CSPIP_PC_W-1:0] target_in,
    input wire int_entry_in,
    input wire [`CSPIP_CTX_W-1:0] ctx_in,
    input wire [7:0] wr_data_in,
    input wire [13:0] prog_rd_data_in,
    input wire [7:0] data_rd_data_in,
    output reg [`CSPIP_PC_W-1:0] pc_out,
    output reg pc_load_out,
    output reg [`CSPIP_CTX_W-1:0] ctx_out,
    output reg ctx_restore_out,
    output reg stack_overflow_flag_out,
    output reg stack_underflow_flag_out,
    output reg soft_reset_out,
    output reg [`CSPIP_PTR_W-1:0] ptr0_out,
    output reg [`CSPIP_PTR_W-1:0] ptr1_out,
    output reg [`CSPIP_PROG_ADDR_W-1:0] prog_addr_out,
    output reg prog_rd_out,
    output reg [`CSPIP_DATA_ADDR_W-1:0] data_addr_out,
    output reg data_rd_out,
    output reg data_wr_out,
    output reg [7:0] data_wr_data_out,
    output reg [7:0] rd_data_out,
    output reg rd_valid_out,
    output reg busy_out
);

    // ****************************************
    // state
    // ****************************************
    localparam ST_RUN = 1'b0;
    localparam ST_PFETCH = 1'b1;

    reg [`CSPIP_PC_W-1:0] stack_mem [0:`CSPIP_STK_DEPTH-1];
    reg [`CSPIP_STK_PTR_W-1:0] sp_r;
    reg stk_full_r;
    reg stk_empty_r;
    reg [`CSPIP_CTX_W-1:0] shadow_r;
    reg [`CSPIP_PTR_W-1:0] ptr_r [0:1];
    reg state_r;
    reg ack_pending_r;
    reg rst_seen_r;

    wire [`CSPIP_PTR_W-1:0] cur_ptr = ptr_r[ptr_sel_in];
    wire is_push = op_valid_in && (op_in == `CSPIP_OP_CALL || int_entry_in) && !busy_out;
    wire is_pop = op_valid_in && (op_in == `CSPIP_OP_RET || op_in == `CSPIP_OP_RETFIE) && !busy_out;
    wire is_prog = cur_ptr[`CSPIP_PTR_PROG_BIT];

    // ****************************************
    // linear window to banked address
    // ****************************************
    reg [`CSPIP_DATA_ADDR_W-1:0] dmap;
    reg [`CSPIP_PTR_W-1:0] lin_ofs;
    reg [`CSPIP_PTR_W-1:0] lin_bank;
    reg [`CSPIP_PTR_W-1:0] lin_rem;
    // sized copy keeps the divide and multiply at pointer width
    localparam [`CSPIP_PTR_W-1:0] GPR_CHUNK = `CSPIP_GPR_BANK_BYTES;
    always @* begin
        lin_ofs = cur_ptr - `CSPIP_LIN_BASE;
        lin_bank = lin_ofs / GPR_CHUNK;
        lin_rem = lin_ofs - lin_bank * GPR_CHUNK;
        if (cur_ptr >= `CSPIP_LIN_BASE && cur_ptr <= `CSPIP_LIN_TOP) begin
            // each bank donates its 80 gpr bytes, gaps skipped
            dmap = lin_bank[4:0] * `CSPIP_BANK_SIZE + lin_rem[6:0] + `CSPIP_GPR_OFS;
        end else begin
            dmap = cur_ptr[`CSPIP_DATA_ADDR_W-1:0];
        end
    end

    // ****************************************
    // sequential logic
    // ****************************************
    integer i;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (i = 0; i < `CSPIP_STK_DEPTH; i = i + 1) begin
                stack_mem[i] <= {`CSPIP_PC_W{1'b0}};
            end
            sp_r <= {`CSPIP_STK_PTR_W{1'b0}};
            stk_full_r <= 1'b0;
            stk_empty_r <= 1'b1;
            shadow_r <= {`CSPIP_CTX_W{1'b0}};
            ptr_r[0] <= 16'h0000;
            ptr_r[1] <= 16'h0000;
            state_r <= ST_RUN;
            ack_pending_r <= 1'b0;
            rst_seen_r <= 1'b0;
            pc_out <= `CSPIP_RESET_VEC;
            pc_load_out <= 1'b0;
            ctx_out <= {`CSPIP_CTX_W{1'b0}};
            ctx_restore_out <= 1'b0;
            stack_overflow_flag_out <= 1'b0;
            stack_underflow_flag_out <= 1'b0;
            soft_reset_out <= 1'b0;
            ptr0_out <= 16'h0000;
            ptr1_out <= 16'h0000;
            prog_addr_out <= {`CSPIP_PROG_ADDR_W{1'b0}};
            prog_rd_out <= 1'b0;
            data_addr_out <= {`CSPIP_DATA_ADDR_W{1'b0}};
            data_rd_out <= 1'b0;
            data_wr_out <= 1'b0;
            data_wr_data_out <= 8'h00;
            rd_data_out <= 8'h00;
            rd_valid_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            pc_load_out <= 1'b0;
            ctx_restore_out <= 1'b0;
            soft_reset_out <= 1'b0;
            prog_rd_out <= 1'b0;
            data_rd_out <= 1'b0;
            data_wr_out <= 1'b0;
            rd_valid_out <= 1'b0;
            // first cycle out of reset loads the reset vector
            if (!rst_seen_r) begin
                rst_seen_r <= 1'b1;
                pc_out <= `CSPIP_RESET_VEC;
                pc_load_out <= 1'b1;
            end
            if (ack_pending_r) begin
                ack_pending_r <= 1'b0;
                rd_data_out <= data_rd_data_in;
                rd_valid_out <= 1'b1;
            end
            // ********** push / pop **********
            if (is_push) begin
                if (stk_full_r) begin
                    // overflow: flag stays until reset, entry not written
                    stack_overflow_flag_out <= 1'b1;
                    soft_reset_out <= stack_reset_en_in;
                end else begin
                    stack_mem[sp_r] <= pc_in;
                    sp_r <= sp_r + 4'h1;
                    stk_empty_r <= 1'b0;
                    stk_full_r <= (sp_r == 4'hf);
                end
                pc_load_out <= 1'b1;
                if (int_entry_in) begin
                    pc_out <= `CSPIP_INT_VEC;
                    shadow_r <= ctx_in;
                end else begin
                    pc_out <= target_in;
                end
            end
            if (is_pop) begin
                if (stk_empty_r) begin
                    stack_underflow_flag_out <= 1'b1;
                    soft_reset_out <= stack_reset_en_in;
                end else begin
                    pc_out <= stack_mem[sp_r - 4'h1];
                    pc_load_out <= 1'b1;
                    sp_r <= sp_r - 4'h1;
                    stk_full_r <= 1'b0;
                    stk_empty_r <= (sp_r == 4'h1);
                end
                if (op_in == `CSPIP_OP_RETFIE) begin
                    ctx_out <= shadow_r;
                    ctx_restore_out <= 1'b1;
                end
            end
            // ********** pointer ops **********
            case (state_r)
                ST_RUN: begin
                    if (op_valid_in && !int_entry_in) begin
                        case (op_in)
                            `CSPIP_OP_PTR_LOAD: ptr_r[ptr_sel_in] <= ptr_value_in;
                            `CSPIP_OP_PTR_ADD: ptr_r[ptr_sel_in] <= cur_ptr + ptr_value_in;
                            `CSPIP_OP_IND_RD: begin
                                if (is_prog) begin
                                    // low 13 bits only, upper addresses wrap
                                    prog_addr_out <= cur_ptr[`CSPIP_PROG_ADDR_W-1:0];
                                    prog_rd_out <= 1'b1;
                                    busy_out <= 1'b1;
                                    state_r <= ST_PFETCH;
                                end else begin
                                    data_addr_out <= dmap;
                                    data_rd_out <= 1'b1;
                                    ack_pending_r <= 1'b1;
                                end
                            end
                            `CSPIP_OP_IND_WR: begin
                                // program memory is read-only through this path
                                if (!is_prog) begin
                                    data_addr_out <= dmap;
                                    data_wr_data_out <= wr_data_in;
                                    data_wr_out <= 1'b1;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_PFETCH: begin
                    // extra cycle: word arrives now, only the low byte returns
                    rd_data_out <= prog_rd_data_in[7:0];
                    rd_valid_out <= 1'b1;
                    busy_out <= 1'b0;
                    state_r <= ST_RUN;
                end
                default: state_r <= ST_RUN;
            endcase
            ptr0_out <= ptr_r[0];
            ptr1_out <= ptr_r[1];
        end
    end

endmodule // cspip_core

// >>> verif/cspip_mem_model.sv
/* far-side memory model for cspip_core: answers program and data reads.
   assumes the read strobes stand for one cycle and data is taken on the next edge. */
`timescale 1ns/1ps
module cspip_mem_model (
    input wire prog_rd_in,
    input wire [12:0] prog_addr_in,
    input wire data_rd_in,
    input wire [11:0] data_addr_in,
    output logic [13:0] prog_data_out,
    output logic [7:0] data_data_out
);
    // off-cycle the lines show the inverse, so a late or early sample never matches
    assign prog_data_out = prog_rd_in ? ({1'b1, prog_addr_in} ^ 14'h15a5) : ~({1'b1, prog_addr_in} ^ 14'h15a5);
    assign data_data_out = data_rd_in ? (data_addr_in[7:0] ^ 8'h3c) : ~(data_addr_in[7:0] ^ 8'h3c);
endmodule // cspip_mem_model

// >>> verif/cspip_core_monitor.sv
/* assertion checker for cspip_core: vectors, stack flags, read handshakes.
   assumes it is bound onto the cspip_core ports and the design header is visible. */
`timescale 1ns/1ps
`include "cspip_defs.vh"
module cspip_monitor (
    input wire clk_in,
    input wire sys_rst_in,
    input wire stack_reset_en_in,
    input wire op_valid_in,
    input wire [`CSPIP_OP_W-1:0] op_in,
    input wire [`CSPIP_PC_W-1:0] target_in,
    input wire int_entry_in,
    input wire [13:0] prog_rd_data_in,
    input wire [7:0] data_rd_data_in,
    input wire [`CSPIP_PC_W-1:0] pc_out,
    input wire pc_load_out,
    input wire stack_overflow_flag_out,
    input wire stack_underflow_flag_out,
    input wire soft_reset_out,
    input wire prog_rd_out,
    input wire data_rd_out,
    input wire [7:0] rd_data_out,
    input wire rd_valid_out,
    input wire busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire take = op_valid_in && !busy_out;
    wire [7:0] prog_lo = prog_rd_data_in[7:0];
    property p_call; take && !int_entry_in && op_in == `CSPIP_OP_CALL |=> pc_load_out && pc_out == $past(target_in); endproperty
    a_call: assert property (p_call) else $error("call target not loaded");
    property p_irq; take && int_entry_in |=> pc_load_out && pc_out == `CSPIP_INT_VEC; endproperty
    a_irq: assert property (p_irq) else $error("interrupt vector not loaded");
    property p_rstvec; $fell(sys_rst_in) |-> ##[0:1] (pc_load_out && pc_out == `CSPIP_RESET_VEC); endproperty
    a_rstvec: assert property (p_rstvec) else $error("reset vector not loaded");
    property p_ovf; stack_overflow_flag_out |=> stack_overflow_flag_out; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag dropped");
    property p_unf; stack_underflow_flag_out |=> stack_underflow_flag_out; endproperty
    a_unf: assert property (p_unf) else $error("underflow flag dropped");
    property p_soft; soft_reset_out |-> $past(stack_reset_en_in); endproperty
    a_soft: assert property (p_soft) else $error("soft reset while disabled");
    property p_prog; prog_rd_out |-> busy_out ##1 (rd_valid_out && !busy_out && rd_data_out == $past(prog_lo)); endproperty
    a_prog: assert property (p_prog) else $error("program read answer wrong");
    property p_data; data_rd_out |=> rd_valid_out && rd_data_out == $past(data_rd_data_in); endproperty
    a_data: assert property (p_data) else $error("data read answer wrong");
    property p_busy; busy_out |=> !busy_out; endproperty
    a_busy: assert property (p_busy) else $error("busy longer than one cycle");
endmodule // cspip_monitor
bind cspip_core cspip_monitor mon (.clk_in, .sys_rst_in, .stack_reset_en_in, .op_valid_in, .op_in, .target_in,
    .int_entry_in, .prog_rd_data_in, .data_rd_data_in, .pc_out, .pc_load_out, .stack_overflow_flag_out,
    .stack_underflow_flag_out, .soft_reset_out, .prog_rd_out, .data_rd_out, .rd_data_out, .rd_valid_out, .busy_out);

// >>> verif/cspip_core_test.sv
/* self-checking bench for cspip_core with the memory model on its read ports.
   assumes cspip_core, cspip_mem_model and the bound checker are compiled first. */
`timescale 1ns/1ps
module cspip_core_test;
    logic clk_in = 0, sys_rst_in = 1, stack_reset_en_in = 0, op_valid_in = 0, ptr_sel_in = 0, int_entry_in = 0;
    logic [2:0] op_in = 0;
    logic [15:0] ptr_value_in = 0, ptr0_out, ptr1_out, v;
    logic [14:0] pc_in = 0, target_in = 0, pc_out;
    logic [61:0] ctx_in = 0, ctx_out, ctx_saved;
    logic [7:0] wr_data_in = 0, data_wr_data_out, rd_data_out, data_rd_data_in;
    logic [13:0] prog_rd_data_in;
    logic [12:0] prog_addr_out;
    logic [11:0] data_addr_out;
    logic pc_load_out, ctx_restore_out, stack_overflow_flag_out, stack_underflow_flag_out, soft_reset_out;
    logic prog_rd_out, data_rd_out, data_wr_out, rd_valid_out, busy_out;
    int bad_count = 0, checked = 0, soft_cnt = 0, wr_cnt = 0, seed = 0;
    logic [63:0] exp_pc[$], exp_rd[$], exp_ctx[$], exp_wr[$];
    logic [15:0] tp[2] = '{16'h0000, 16'h0000};
    logic [14:0] stk[$];
    cspip_core dut (.*);
    cspip_mem_model mem (.prog_rd_in(prog_rd_out), .prog_addr_in(prog_addr_out), .data_rd_in(data_rd_out),
        .data_addr_in(data_addr_out), .prog_data_out(prog_rd_data_in), .data_data_out(data_rd_data_in));
    initial forever #12.5 clk_in = ~clk_in;
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic rst_dut();
        @(posedge clk_in);
        #2;
        sys_rst_in = 1;
        stk.delete();
        tp = '{16'h0000, 16'h0000};
        repeat (3) @(posedge clk_in);
        #2;
        sys_rst_in = 0;
        exp_pc.push_back(0);
    endtask
    // the driver notes every pc and context result the op must cause, mirroring the stack
    task automatic do_op(logic [2:0] op, logic sel = 0, logic [15:0] val = 0, logic [14:0] tgt = 0, logic irq = 0);
        @(posedge clk_in);
        #2;
        {op_valid_in, op_in, ptr_sel_in, ptr_value_in, target_in, int_entry_in} = {1'b1, op, sel, val, tgt, irq};
        pc_in = 15'($urandom);
        ctx_in = 62'({$urandom, $urandom});
        wr_data_in = 8'($urandom);
        if (irq) ctx_saved = ctx_in;
        if (op == 1 || irq) exp_pc.push_back(irq ? 64'h4 : 64'(tgt));
        if ((op == 1 || irq) && stk.size() < 16) stk.push_back(pc_in);
        if ((op == 2 || op == 3) && stk.size() > 0) exp_pc.push_back(64'(stk.pop_back()));
        if (op == 3) exp_ctx.push_back(64'(ctx_saved));
        if (op == 5) tp[sel] = val;
        if (op == 4) tp[sel] = tp[sel] + val;
        if (op == 7 && !tp[sel][15]) exp_wr.push_back(64'(wr_data_in));
        @(posedge clk_in);
        #2;
        op_valid_in = 0;
        while (busy_out === 1'b1) begin
            @(posedge clk_in);
            #2;
        end
    endtask
    // ****************************************
    // result watcher and tests
    // ****************************************
    always @(posedge clk_in) if (!sys_rst_in) begin
        if (pc_load_out === 1'b1) chk("pc", exp_pc.size() ? exp_pc.pop_front() : '1, 64'(pc_out));
        if (ctx_restore_out === 1'b1) chk("ctx", exp_ctx.size() ? exp_ctx.pop_front() : '1, 64'(ctx_out));
        if (rd_valid_out === 1'b1) chk("read", exp_rd.size() ? exp_rd.pop_front() : '1, 64'(rd_data_out));
        if (soft_reset_out === 1'b1) soft_cnt++;
        if (data_wr_out === 1'b1) begin
            wr_cnt++;
            chk("write data", exp_wr.size() ? exp_wr.pop_front() : '1, 64'(data_wr_data_out));
        end
    end
    initial begin
        #(25 * 3000);
        bad_count++;
        end_of_test();
    end
    initial begin
        seed = $urandom(41);
        rst_dut();
        for (int i = 0; i < 17; i++) do_op(1, 0, 0, 15'($urandom));
        chk("overflow flag", 1, 64'(stack_overflow_flag_out));
        for (int i = 0; i < 17; i++) do_op(2);
        chk("underflow flag", 1, 64'(stack_underflow_flag_out));
        do_op(0, 0, 0, 0, 1);
        do_op(1, 0, 0, 15'($urandom));
        do_op(2);
        do_op(3);
        for (int i = 0; i < 4; i++) begin
            v = 16'h8000 | 16'($urandom);
            exp_rd.push_back(64'(v[7:0] ^ 8'ha5));
            do_op(5, i[0], v);
            do_op(6, i[0]);
            chk("pointer", 64'(v), 64'(i[0] ? ptr1_out : ptr0_out));
            do_op(7, i[0]);
        end
        // the write pulse is counted one edge after the op returns
        repeat (2) @(posedge clk_in);
        chk("prog writes", 0, 64'(wr_cnt));
        do_op(5, 1, 16'h2000);
        do_op(4, 1, 16'h0050);
        exp_rd.push_back(64'(8'ha0 ^ 8'h3c));
        do_op(6, 1);
        do_op(7, 1);
        repeat (2) @(posedge clk_in);
        chk("data writes", 1, 64'(wr_cnt));
        chk("write addr", 64'h0a0, 64'(data_addr_out));
        chk("soft resets off", 0, 64'(soft_cnt));
        stack_reset_en_in = 1;
        rst_dut();
        do_op(2);
        repeat (3) @(posedge clk_in);
        chk("soft resets on", 1, 64'(soft_cnt));
        chk("leftover", 0, 64'(exp_pc.size() + exp_rd.size() + exp_ctx.size() + exp_wr.size()));
        end_of_test();
    end
endmodule // cspip_core_test
